// File: rtl/irt_pkg.sv
package irt_pkg;
	// ==========================================
	// register file geometry
	localparam int unsigned ADDR_W            = 8;
	localparam int unsigned DATA_W            = 8;
	localparam logic [7:0]  BANK_PTR_ADDR     = 8'hfd;
	localparam logic [3:0]  BANK_TIMER        = 4'hd;
	localparam logic [3:0]  BANK_NORMAL       = 4'h0;
	localparam logic [3:0]  BANK_SPARE        = 4'hf;
	localparam logic [7:0]  BANK_PTR_RESET    = 8'h00;
	// ==========================================
	// bank d offsets
	localparam logic [3:0]  OFS_CONTROL       = 4'h0;
	localparam logic [3:0]  OFS_T8_LOW_HOLD   = 4'h4;
	localparam logic [3:0]  OFS_T8_HIGH_HOLD  = 4'h5;
	localparam logic [3:0]  OFS_T16_HOLD_LO   = 4'h6;
	localparam logic [3:0]  OFS_T16_HOLD_HI   = 4'h7;
	localparam logic [3:0]  OFS_T16_CAP_LO    = 4'h8;
	localparam logic [3:0]  OFS_T16_CAP_HI    = 4'h9;
	localparam logic [3:0]  OFS_T8_CAP_LOW    = 4'ha;
	localparam logic [3:0]  OFS_T8_CAP_HIGH   = 4'hb;
	// ==========================================
	// control register fields
	localparam int unsigned CTL_RUN_BIT       = 7;
	localparam int unsigned CTL_SINGLE_BIT    = 6;
	localparam int unsigned CTL_TIMEOUT_BIT   = 5;
	localparam int unsigned CTL_PRESC_HI      = 4;
	localparam int unsigned CTL_PRESC_LO      = 3;
	localparam int unsigned CTL_CAP_MASK_BIT  = 2;
	localparam int unsigned CTL_CNT_MASK_BIT  = 1;
	localparam int unsigned CTL_ROUTE_BIT     = 0;
	localparam logic [7:0]  CONTROL_RESET     = 8'h00;
	localparam logic [7:0]  HOLD_RESET        = 8'h00;
	localparam logic [2:0]  PRESC_RESET       = 3'h0;
endpackage

// File: rtl/irt_sync.sv
`timescale 1ns/1ps
module irt_sync (
	input  wire logic clk_sys_in,
	input  wire logic reset_n_in,
	input  wire logic async_in,
	output logic      sync_out
);
	typedef struct packed {
		logic first;
		logic second;
	} irt_sync_s;
	irt_sync_s state;
	irt_sync_s next_state;
	// ==========================================
	// two-stage synchroniser, first stage feeds only the second
	always_comb begin
		next_state.first  = async_in;
		next_state.second = state.first;
	end
	always_ff @(posedge clk_sys_in) begin
		if (!reset_n_in) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end
	assign sync_out = state.second;
endmodule

// File: rtl/irt_prescaler.sv
`timescale 1ns/1ps
module irt_prescaler (
	input  wire logic       clk_sys_in,
	input  wire logic       reset_n_in,
	input  wire logic       run_in,
	input  wire logic [1:0] select_in,
	output logic            tick_out
);
	import irt_pkg::*;
	typedef struct packed {
		logic [2:0] count;
	} irt_presc_s;
	irt_presc_s state;
	irt_presc_s next_state;
	logic [2:0] limit;
	// ==========================================
	// divide by 1, 2, 4 or 8; held in reset while stopped
	always_comb begin
		limit = 3'((4'h1 << select_in) - 4'h1);
		next_state = state;
		if (!run_in || state.count >= limit) begin
			next_state.count = 3'h0;
		end else begin
			next_state.count = 3'(state.count + 3'h1);
		end
	end
	always_ff @(posedge clk_sys_in) begin
		if (!reset_n_in) begin
			state.count <= PRESC_RESET;
		end else begin
			state <= next_state;
		end
	end
	assign tick_out = run_in && (state.count >= limit); // (RL18)
endmodule

// File: rtl/irt_timer_bank.sv
`timescale 1ns/1ps
// Function
// (RL1) timer registers live only in bank d
// (RL2) pointer upper nibble picks working group
// (RL3) lower nibble zero reaches normal file
// (RL4) nonzero nibble swaps low sixteen locations; here only nibble d swaps them, other nibbles reach the normal file
// (RL5) capture-high holds count while input high
// (RL6) capture-low holds count while input low
// (RL7) offset 09 holds capture high byte
// (RL8) offset 08 holds capture low byte
// (RL9) capture registers ignore software writes
// (RL10) sixteen-bit hold bytes at 07, 06
// (RL11) eight-bit hold values at 05, 04
// (RL12) control bit 7 starts and stops counter
// (RL13) control bit 2 gates capture interrupt
// (RL14) mode bit: reload or stop at end
// (RL15) time-out flag set at end, write-1 clears
// (RL16) counter mask gates time-out interrupt
// (RL17) control bit 0 routes port pin
// (RL18) bits 4:3 pick clock divide 1..8
// (RL19) writing zero leaves time-out flag alone
module irt_timer_bank #(
	parameter int unsigned DATA_WIDTH = 8
) (
	input  wire logic                     clk_sys_in,
	input  wire logic                     reset_n_in,
	// processor register access, one cycle strobes
	input  wire logic [irt_pkg::ADDR_W-1:0] reg_addr_in,
	input  wire logic [irt_pkg::DATA_W-1:0] reg_wdata_in,
	input  wire logic                     reg_write_in,
	input  wire logic                     reg_read_in,
	output logic      [irt_pkg::DATA_W-1:0] reg_rdata_out,
	output logic                          reg_hit_out,
	output logic      [irt_pkg::ADDR_W-1:0] file_addr_out,
	// timers
	input  wire logic                     demod_pin_in,
	input  wire logic                     port_bit_in,
	input  wire logic [15:0]              timer16_count_in,
	input  wire logic                     timer16_capture_in,
	output logic                          port3_bit4_pin_out,
	output logic                          timeout_irq_out,
	output logic                          capture_irq_out,
	output logic      [15:0]              timer16_hold_out
);
	import irt_pkg::*;

	// refused at elaboration: the register map is byte wide throughout
	if (DATA_WIDTH != DATA_W) begin : g_width_check
		$error("irt_timer_bank supports only 8-bit registers");
	end

	typedef struct packed {
		logic [7:0] bank_ptr;
		logic       run;
		logic       single;
		logic       timeout;
		logic [1:0] presc;
		logic       cap_mask;
		logic       cnt_mask;
		logic       route;
		logic [7:0] low_hold;
		logic [7:0] high_hold;
		logic [7:0] t16_hold_lo;
		logic [7:0] t16_hold_hi;
		logic [7:0] t16_cap_lo;
		logic [7:0] t16_cap_hi;
		logic [7:0] cap_low;
		logic [7:0] cap_high;
		logic [7:0] count;
		logic [7:0] elapsed;
		logic       level;
		logic       level_prev;
		logic       t8_out;
		logic [7:0] rdata;
		logic       timeout_irq;
		logic       capture_irq;
	} irt_bank_s;

	irt_bank_s state;
	irt_bank_s next_state;
	logic      demod_sync;
	logic      tick;
	logic      in_bank;
	logic      ptr_hit;
	logic      terminal;
	logic      edge_seen;
	logic [3:0] ofs;

	// ==========================================
	// pin input synchroniser and clock prescaler
	irt_sync u_sync (
		.clk_sys_in (clk_sys_in),
		.reset_n_in (reset_n_in),
		.async_in   (demod_pin_in),
		.sync_out   (demod_sync)
	);

	irt_prescaler u_presc (
		.clk_sys_in (clk_sys_in),
		.reset_n_in (reset_n_in),
		.run_in     (state.run),
		.select_in  (state.presc),
		.tick_out   (tick)
	);

	// ==========================================
	// address decode
	always_comb begin
		ofs     = reg_addr_in[3:0];
		ptr_hit = (reg_addr_in == BANK_PTR_ADDR);
		// only the low sixteen locations are swapped, and only for bank d
		in_bank = (reg_addr_in[7:4] == 4'h0) && (state.bank_ptr[3:0] == BANK_TIMER); // (RL1) (RL4)
		// short register addresses land in the group chosen by the upper nibble
		file_addr_out = {state.bank_ptr[7:4], reg_addr_in[3:0]}; // (RL2)
		// bank 0 and the spare bank f fall through to the ordinary file
		reg_hit_out = in_bank || ptr_hit; // (RL3)
	end

	// ==========================================
	// counter, capture and register file
	always_comb begin
		next_state = state;
		terminal   = tick && (state.count == 8'h00);
		edge_seen  = (state.level != state.level_prev);
		next_state.level_prev = state.level;
		next_state.level      = demod_sync;
		next_state.timeout_irq = 1'b0;
		next_state.capture_irq = 1'b0;

		// counting down from the hold value matching the output level
		if (state.run && tick) begin
			if (terminal) begin
				next_state.t8_out = !state.t8_out;
				next_state.count  = state.t8_out ? state.low_hold : state.high_hold;
				if (state.single) begin
					next_state.run = 1'b0; // (RL14)
				end
			end else begin
				next_state.count = 8'(state.count - 8'h01);
			end
		end

		// ticks spent at the present input level; saturates so a long level reads ff
		// own counter, so reloads of the down-counter cannot corrupt a capture
		if (state.run && tick && (state.elapsed != 8'hff)) begin
			next_state.elapsed = 8'(state.elapsed + 8'h01);
		end

		// capture the length of the finished level on each input edge while running
		if (edge_seen && state.run) begin
			if (state.level_prev) begin
				next_state.cap_high = state.elapsed; // (RL5)
			end else begin
				next_state.cap_low = state.elapsed; // (RL6)
			end
			next_state.elapsed     = 8'h00;
			next_state.capture_irq = state.cap_mask; // (RL13)
		end

		if (timer16_capture_in) begin
			next_state.t16_cap_hi = timer16_count_in[15:8]; // (RL7)
			next_state.t16_cap_lo = timer16_count_in[7:0]; // (RL8)
		end

		// ==========================================
		// register writes; capture offsets have no write path
		if (reg_write_in && ptr_hit) begin
			next_state.bank_ptr = reg_wdata_in;
		end
		if (reg_write_in && in_bank) begin
			case (ofs)
				OFS_CONTROL: begin
					next_state.run      = reg_wdata_in[CTL_RUN_BIT]; // (RL12)
					next_state.single   = reg_wdata_in[CTL_SINGLE_BIT];
					next_state.presc    = reg_wdata_in[CTL_PRESC_HI:CTL_PRESC_LO]; // (RL18)
					next_state.cap_mask = reg_wdata_in[CTL_CAP_MASK_BIT];
					next_state.cnt_mask = reg_wdata_in[CTL_CNT_MASK_BIT];
					next_state.route    = reg_wdata_in[CTL_ROUTE_BIT];
					if (reg_wdata_in[CTL_RUN_BIT] && !state.run) begin
						next_state.count   = state.high_hold;
						next_state.t8_out  = 1'b1;
						next_state.elapsed = 8'h00;
					end
					if (reg_wdata_in[CTL_TIMEOUT_BIT]) begin
						next_state.timeout = 1'b0; // (RL15) (RL19)
					end
				end
				OFS_T8_LOW_HOLD:  next_state.low_hold    = reg_wdata_in; // (RL11)
				OFS_T8_HIGH_HOLD: next_state.high_hold   = reg_wdata_in; // (RL11)
				OFS_T16_HOLD_LO:  next_state.t16_hold_lo = reg_wdata_in; // (RL10)
				OFS_T16_HOLD_HI:  next_state.t16_hold_hi = reg_wdata_in; // (RL10)
				default: begin
					next_state.bank_ptr = next_state.bank_ptr; // (RL9)
				end
			endcase
		end

		// set wins over a same-cycle clear
		if (state.run && terminal) begin
			next_state.timeout     = 1'b1; // (RL15)
			next_state.timeout_irq = state.cnt_mask; // (RL16)
		end

		// ==========================================
		// read data registered for the processor
		next_state.rdata = 8'h00;
		if (reg_read_in && ptr_hit) begin
			next_state.rdata = state.bank_ptr;
		end else if (reg_read_in && in_bank) begin
			case (ofs)
				OFS_CONTROL: next_state.rdata = {state.run, state.single, state.timeout,
					state.presc, state.cap_mask, state.cnt_mask, state.route};
				OFS_T8_LOW_HOLD:  next_state.rdata = state.low_hold;
				OFS_T8_HIGH_HOLD: next_state.rdata = state.high_hold;
				OFS_T16_HOLD_LO:  next_state.rdata = state.t16_hold_lo;
				OFS_T16_HOLD_HI:  next_state.rdata = state.t16_hold_hi;
				OFS_T16_CAP_LO:   next_state.rdata = state.t16_cap_lo;
				OFS_T16_CAP_HI:   next_state.rdata = state.t16_cap_hi;
				OFS_T8_CAP_LOW:   next_state.rdata = state.cap_low;
				OFS_T8_CAP_HIGH:  next_state.rdata = state.cap_high;
				default:          next_state.rdata = 8'h00;
			endcase
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (!reset_n_in) begin
			state          <= '0;
			state.bank_ptr <= BANK_PTR_RESET;
			state.low_hold <= HOLD_RESET;
		end else begin
			state <= next_state;
		end
	end

	// ==========================================
	// outputs
	assign reg_rdata_out      = state.rdata;
	assign port3_bit4_pin_out = state.route ? state.t8_out : port_bit_in; // (RL17)
	assign timeout_irq_out    = state.timeout_irq;
	assign capture_irq_out    = state.capture_irq;
	assign timer16_hold_out   = {state.t16_hold_hi, state.t16_hold_lo};
endmodule

// File: tb/irt_file_model.sv
`timescale 1ns/1ps
// ====
// normal register file seen through the working group
module irt_file_model (
	input  wire logic       clk_in,
	input  wire logic       we_in,
	input  wire logic [7:0] addr_in,
	input  wire logic [7:0] wdata_in,
	output logic      [7:0] rdata_out
);
	logic [7:0] mem [256];
	// cleared so bank 0 reads never look like timer data
	initial begin
		foreach (mem[i]) mem[i] = 8'h00;
	end
	always @(posedge clk_in) begin
		if (we_in) begin
			mem[addr_in] <= wdata_in;
		end
	end
	assign rdata_out = mem[addr_in];
endmodule

// File: tb/irt_timer_bank_properties.sv
`timescale 1ns/1ps
module irt_timer_bank_properties
	import irt_pkg::*;
(
	input wire logic                     clk_sys_in,
	input wire logic                     reset_n_in,
	input wire logic [irt_pkg::ADDR_W-1:0] reg_addr_in,
	input wire logic [irt_pkg::DATA_W-1:0] reg_wdata_in,
	input wire logic                     reg_write_in,
	input wire logic                     reg_hit_out,
	input wire logic [irt_pkg::ADDR_W-1:0] file_addr_out,
	input wire logic                     port_bit_in,
	input wire logic                     port3_bit4_pin_out,
	input wire logic                     timeout_irq_out,
	input wire logic                     capture_irq_out,
	input wire logic [15:0]              timer16_hold_out
);
	// ====
	// shadow of pointer and control, rebuilt from writes
	logic [7:0] ptr;
	logic [7:0] ctl;
	wire low = reg_addr_in[7:4] == 4'h0;
	wire bank_d = low && ptr[3:0] == BANK_TIMER;
	wire wr_d = reg_write_in && bank_d;
	always_ff @(posedge clk_sys_in) begin
		if (!reset_n_in) begin
			ptr <= BANK_PTR_RESET;
			ctl <= CONTROL_RESET;
		end else if (reg_write_in) begin
			if (reg_addr_in == BANK_PTR_ADDR) ptr <= reg_wdata_in;
			if (bank_d && reg_addr_in[3:0] == OFS_CONTROL) ctl <= reg_wdata_in;
		end
	end
	default clocking @(posedge clk_sys_in); endclocking
	default disable iff (!reset_n_in);
	// ====
	// assertions
	a_bank_claim: assert property (bank_d |-> reg_hit_out)
		else $error("bank d access not claimed");
	a_ptr_claim: assert property (reg_addr_in == BANK_PTR_ADDR |-> reg_hit_out)
		else $error("pointer access not claimed");
	a_work_group: assert property (low |-> file_addr_out == {ptr[7:4], reg_addr_in[3:0]})
		else $error("working group address wrong");
	a_swap_miss: assert property (low && ptr[3:0] != BANK_TIMER |-> !reg_hit_out)
		else $error("access claimed outside bank d");
	a_hold_hi: assert property (wr_d && reg_addr_in[3:0] == OFS_T16_HOLD_HI
		|=> timer16_hold_out[15:8] == $past(reg_wdata_in))
		else $error("hold high byte not stored");
	a_hold_lo: assert property (wr_d && reg_addr_in[3:0] == OFS_T16_HOLD_LO
		|=> timer16_hold_out[7:0] == $past(reg_wdata_in))
		else $error("hold low byte not stored");
	a_pin_port: assert property (!ctl[CTL_ROUTE_BIT] |-> port3_bit4_pin_out == port_bit_in)
		else $error("pin not showing port data");
	// irq is registered, so the mask one cycle back also counts
	a_cnt_mask: assert property (!ctl[1] && !$past(ctl[1]) |-> !timeout_irq_out)
		else $error("masked time-out raised irq");
	a_cap_mask: assert property (!ctl[2] && !$past(ctl[2]) |-> !capture_irq_out)
		else $error("masked capture raised irq");
	c_timeout: cover property (timeout_irq_out);
	c_capture: cover property (capture_irq_out);
	c_route: cover property (ctl[0] && port3_bit4_pin_out != port_bit_in);
endmodule
bind irt_timer_bank irt_timer_bank_properties u_props (
	.clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in), .reg_addr_in(reg_addr_in),
	.reg_wdata_in(reg_wdata_in), .reg_write_in(reg_write_in), .reg_hit_out(reg_hit_out),
	.file_addr_out(file_addr_out), .port_bit_in(port_bit_in),
	.port3_bit4_pin_out(port3_bit4_pin_out), .timeout_irq_out(timeout_irq_out),
	.capture_irq_out(capture_irq_out), .timer16_hold_out(timer16_hold_out));

// File: tb/irt_timer_bank_bench.sv
`timescale 1ns/1ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin fail_count++; \
	$display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module irt_timer_bank_bench;
	import irt_pkg::*;
	logic clk_sys_in = 0, reset_n_in = 0, wr = 0, rd = 0, dpin = 0, pbit = 0, cap = 0;
	logic [7:0] addr = 0, wdata = 0, rdata, faddr, got, lo, mdata;
	logic [15:0] cnt16 = 0, hold16;
	logic hit, pin, tirq, cirq;
	int fail_count = 0, n_tests = 0, cyc = 0, ncap = 0, nto = 0, n;
	always #5 clk_sys_in = ~clk_sys_in;
	irt_timer_bank u_dut (.clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in),
		.reg_addr_in(addr), .reg_wdata_in(wdata), .reg_write_in(wr), .reg_read_in(rd),
		.reg_rdata_out(rdata), .reg_hit_out(hit), .file_addr_out(faddr),
		.demod_pin_in(dpin), .port_bit_in(pbit), .timer16_count_in(cnt16),
		.timer16_capture_in(cap), .port3_bit4_pin_out(pin), .timeout_irq_out(tirq),
		.capture_irq_out(cirq), .timer16_hold_out(hold16));
	irt_file_model u_file (.clk_in(clk_sys_in), .we_in(wr && !hit), .addr_in(faddr),
		.wdata_in(wdata), .rdata_out(mdata));
	// ====
	// access tasks
	task wr8(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys_in); addr <= a; wdata <= d; wr <= 1;
		@(posedge clk_sys_in); wr <= 0;
		#1;
	endtask
	task peek(input logic [7:0] a);
		@(posedge clk_sys_in); addr <= a; rd <= 1;
		@(posedge clk_sys_in); rd <= 0;
		#1 got = rdata;
	endtask
	task rd8(input logic [7:0] a, input logic [7:0] e);
		peek(a);
		`CHK(got, e)
	endtask
	task run_to(output int k);
		k = 0;
		while (tirq !== 1'b1 && k < 2000) begin @(posedge clk_sys_in); #1; k++; end
	endtask
	task print_verdict;
		$display("comparisons %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	always @(posedge clk_sys_in) begin
		cyc++;
		if (cirq === 1'b1) ncap++;
		if (tirq === 1'b1) nto++;
		// run needs about 260 cycles
		if (cyc == 5000) begin fail_count++; print_verdict; end
	end
	// ====
	// tests
	initial begin
		repeat (6) @(posedge clk_sys_in);
		reset_n_in <= 1;
		rd8(8'hfd, 8'h00);
		wr8(8'hfd, 8'h0d);
		rd8(8'h00, 8'h00);
		`CHK(hit, 1'b1)
		for (int i = 4; i < 8; i++) wr8(8'(i), 8'h30 + 8'(i));
		for (int i = 4; i < 8; i++) rd8(8'(i), 8'h30 + 8'(i));
		`CHK(hold16, 16'h3736)
		$display("test holds done");
		@(posedge clk_sys_in); cnt16 <= 16'ha55a; cap <= 1;
		@(posedge clk_sys_in); cap <= 0;
		for (int i = 8; i < 12; i++) wr8(8'(i), 8'hff);
		rd8(8'h08, 8'h5a);
		rd8(8'h09, 8'ha5);
		rd8(8'h0a, 8'h00);
		$display("test capture16 done");
		wr8(8'h05, 8'h03);
		wr8(8'h00, 8'h20);
		for (int c = 0; c < 4; c++) begin
			wr8(8'h00, 8'hc2 | 8'(c << 3));
			run_to(n);
			// hold 3 gives four ticks, each one divider period long
			`CHK(n, 4 << c)
			rd8(8'h00, 8'h62 | 8'(c << 3));
			wr8(8'h00, 8'h42);
			rd8(8'h00, 8'h62);
			wr8(8'h00, 8'h20);
			rd8(8'h00, 8'h00);
		end
		// masked time-out: flag set, no request
		wr8(8'h00, 8'hc0);
		repeat (8) @(posedge clk_sys_in);
		rd8(8'h00, 8'h60);
		`CHK(nto, 4)
		wr8(8'h00, 8'h20);
		$display("test timer done");
		wr8(8'h05, 8'hff);
		wr8(8'h00, 8'h84);
		repeat (10) @(posedge clk_sys_in); dpin <= 1;
		repeat (40) @(posedge clk_sys_in); dpin <= 0;
		repeat (8) @(posedge clk_sys_in);
		peek(8'h0a); lo = got;
		peek(8'h0b);
		`CHK(got > lo && lo != 8'h00, 1'b1)
		`CHK(ncap, 2)
		wr8(8'h00, 8'h80);
		@(posedge clk_sys_in); pbit <= 1; dpin <= 1;
		repeat (8) @(posedge clk_sys_in); #1;
		`CHK(ncap, 2)
		`CHK(pin, 1'b1)
		@(posedge clk_sys_in); pbit <= 0;
		wr8(8'h00, 8'h81);
		`CHK(pin, 1'b1)
		$display("test demod done");
		wr8(8'hfd, 8'h30);
		wr8(8'h04, 8'h5a);
		`CHK(faddr, 8'h34)
		`CHK(mdata, 8'h5a)
		`CHK(hit, 1'b0)
		wr8(8'hfd, 8'h3f);
		peek(8'h04);
		`CHK(hit, 1'b0)
		wr8(8'hfd, 8'h0d);
		rd8(8'h04, 8'h34);
		$display("test banks done");
		print_verdict;
	end
endmodule
